// ### hdl/buck_switch_protection_sequencer.sv
`default_nettype none
module buck_switch_protection_sequencer #(
  parameter int SS_STEP_CYC = buck_seq_pkg::SS_STEP_DEF
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        rampCross,
  input  wire logic        zeroCross,
  input  wire logic        overLimit,
  input  wire logic        fbUnder,
  input  wire logic        fbOver,
  input  wire logic        tempHot,
  input  wire logic        fbAboveRamp,
  input  wire logic        fbInWindow,
  input  wire logic        enable,
  input  wire logic        limitPinHigh,
  input  wire logic        limitPinLow,
  input  wire logic [10:0] modeKohm,
  output logic             hsOn,
  output logic             lsOn,
  output logic      [9:0]  ssRefCode,
  output logic      [1:0]  limitLevel,
  output logic             powerSaveOn,
  output logic             drvRegOn,
  output logic             outputGood,
  output logic             goodPullOe,
  output logic             discontinuous,
  output logic             uvFault
);
  typedef struct packed {
    buck_seq_pkg::seq_e   seq;
    buck_seq_pkg::phase_e ph;
    logic [7:0]           phCnt;
    logic                 ocHold;
    logic                 discontinuous_conduction;
    logic [2:0]           dcmRun;
    logic [9:0]           foldCnt;
    logic [9:0]           ssRef;
    logic [11:0]          ssPre;
    logic [13:0]          retryCnt;
    logic [11:0]          uvCnt;
    logic [11:0]          pgCnt;
    logic                 good;
    logic                 pullOe;
    logic                 otHold;
    logic                 uvf;
    logic                 hs;
    logic                 ls;
    logic [1:0]           lim;
    logic                 ps;
    logic                 drv;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  logic [buck_seq_pkg::SYNC_W-1:0] rawPins;
  logic [buck_seq_pkg::SYNC_W-1:0] syncPins;
  logic [10:0]                     sMode;
  logic                            sRamp;
  logic                            sZero;
  logic                            sLimit;
  logic                            sUnder;
  logic                            sOver;
  logic                            sHot;
  logic                            sAbove;
  logic                            sWindow;
  logic                            sEn;
  logic                            sLimHigh;
  logic                            sLimLow;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic inRange(
    input logic [10:0] v,
    input logic [10:0] lo,
    input logic [10:0] hi
  );
    inRange = (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Comparator and pin inputs cross into the clock domain
  // ----------------------------------------------------------------
  assign rawPins = {modeKohm, rampCross, zeroCross, overLimit, fbUnder, fbOver,
                    tempHot, fbAboveRamp, fbInWindow, enable, limitPinHigh,
                    limitPinLow};

  pin_sync #(
    .W (buck_seq_pkg::SYNC_W)
  ) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (rawPins),
    .q      (syncPins)
  );

  assign {sMode, sRamp, sZero, sLimit, sUnder, sOver, sHot, sAbove, sWindow,
          sEn, sLimHigh, sLimLow} = syncPins;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic stepTick;
    logic hotTrip;
    logic swOk;
    logic goodWant;
    stepTick = 1'b0;
    hotTrip  = 1'b0;
    swOk     = 1'b0;
    goodWant = 1'b0;
    s_nxt    = s_r;

    // Mode follows the pin on the fly; an unrecognised value keeps the last
    if (inRange(sMode, buck_seq_pkg::MODE1_LO, buck_seq_pkg::MODE1_HI))
    begin
      s_nxt.ps  = 1'b1;
      s_nxt.drv = 1'b1;
    end
    else if (inRange(sMode, buck_seq_pkg::MODE2_LO, buck_seq_pkg::MODE2_HI))
    begin
      s_nxt.ps  = 1'b0;
      s_nxt.drv = 1'b1;
    end
    else if (inRange(sMode, buck_seq_pkg::MODE3_LO, buck_seq_pkg::MODE3_HI))
    begin
      s_nxt.ps  = 1'b0;
      s_nxt.drv = 1'b0;
    end
    else if (inRange(sMode, buck_seq_pkg::MODE4_LO, buck_seq_pkg::MODE4_HI))
    begin
      s_nxt.ps  = 1'b1;
      s_nxt.drv = 1'b0;
    end

    // Neither strap sensed means the pin floats
    if (sLimHigh)
      s_nxt.lim = buck_seq_pkg::LIM_FULL;
    else if (sLimLow)
      s_nxt.lim = buck_seq_pkg::LIM_HALF;
    else
      s_nxt.lim = buck_seq_pkg::LIM_3Q;

    // ----------------------------------------------------------------
    // Start-up sequencer
    // ----------------------------------------------------------------
    stepTick = (s_r.ssPre == 12'(SS_STEP_CYC - 1));
    s_nxt.ssPre = stepTick ? 12'h000 : s_r.ssPre + 12'h001;
    // A hot die while the inductor current is discontinuous is not acted on
    hotTrip = sHot && !s_r.discontinuous_conduction;
    if (hotTrip)
      s_nxt.otHold = 1'b1;
    else if (!sHot)
      s_nxt.otHold = 1'b0;
    s_nxt.uvCnt = 12'h000;

    unique case (s_r.seq)
      buck_seq_pkg::SEQ_STOP:
      begin
        s_nxt.ssRef = 10'h000;
        if (sEn && !s_r.otHold)
        begin
          s_nxt.seq   = buck_seq_pkg::SEQ_SOFT;
          s_nxt.ssPre = 12'h000;
        end
      end
      buck_seq_pkg::SEQ_SOFT:
      begin
        if (s_r.ssRef == buck_seq_pkg::SS_FINAL)
          s_nxt.seq = buck_seq_pkg::SEQ_RUN;
        else if (stepTick)
          s_nxt.ssRef = s_r.ssRef + 10'h001;
      end
      buck_seq_pkg::SEQ_RUN:
      begin
        // Only armed here, after the reference has reached its end value
        if (sUnder)
        begin
          if (s_r.uvCnt == 12'(buck_seq_pkg::UV_CYC))
          begin
            s_nxt.seq      = buck_seq_pkg::SEQ_RETRY;
            s_nxt.uvf      = 1'b1;
            s_nxt.retryCnt = 14'h0000;
            s_nxt.ssPre    = 12'h000;
          end
          else
            s_nxt.uvCnt = s_r.uvCnt + 12'h001;
        end
      end
      buck_seq_pkg::SEQ_RETRY:
      begin
        s_nxt.ssRef = 10'h000;
        if (stepTick)
        begin
          if (s_r.retryCnt == 14'(buck_seq_pkg::RETRY_STEPS - 1))
          begin
            s_nxt.seq = buck_seq_pkg::SEQ_SOFT;
            s_nxt.uvf = 1'b0;
          end
          else
            s_nxt.retryCnt = s_r.retryCnt + 14'h0001;
        end
      end
    endcase

    // Enable low and thermal trip win over every sequencer state
    if (!sEn || hotTrip)
    begin
      s_nxt.seq   = buck_seq_pkg::SEQ_STOP;
      s_nxt.ssRef = 10'h000;
      s_nxt.uvf   = 1'b0;
    end

    // ----------------------------------------------------------------
    // Switch phase
    // ----------------------------------------------------------------
    // Next sequencer state, so a fault stops both switches on the edge it is declared
    swOk = (s_nxt.seq == buck_seq_pkg::SEQ_SOFT || s_nxt.seq == buck_seq_pkg::SEQ_RUN)
           && sEn && !hotTrip
           && !sOver
           && !(s_nxt.seq == buck_seq_pkg::SEQ_SOFT && sAbove);

    if (!swOk)
    begin
      s_nxt.ph      = buck_seq_pkg::PH_WAIT;
      s_nxt.phCnt   = 8'h00;
      s_nxt.foldCnt = 10'h000;
    end
    else
    begin
      unique case (s_r.ph)
        buck_seq_pkg::PH_WAIT:
        begin
          if (s_r.foldCnt != 10'h000)
            s_nxt.foldCnt = s_r.foldCnt - 10'h001;
          else if (sRamp && !s_r.ocHold)
          begin
            s_nxt.ph    = buck_seq_pkg::PH_ON;
            s_nxt.phCnt = 8'(buck_seq_pkg::ON_CYC - 1);
          end
        end
        buck_seq_pkg::PH_ON:
        begin
          if (s_r.phCnt == 8'h00)
          begin
            s_nxt.ph    = buck_seq_pkg::PH_DEAD;
            s_nxt.phCnt = 8'(buck_seq_pkg::DEAD_CYC - 1);
          end
          else
            s_nxt.phCnt = s_r.phCnt - 8'h01;
        end
        buck_seq_pkg::PH_DEAD:
        begin
          if (s_r.phCnt == 8'h00)
          begin
            s_nxt.ph    = buck_seq_pkg::PH_LOW;
            s_nxt.phCnt = 8'h00;
          end
          else
            s_nxt.phCnt = s_r.phCnt - 8'h01;
        end
        buck_seq_pkg::PH_LOW:
        begin
          if (s_r.phCnt != 8'(buck_seq_pkg::MIN_OFF_CYC))
            s_nxt.phCnt = s_r.phCnt + 8'h01;
          // Switching noise makes the first samples of the sense worthless
          if (s_r.phCnt >= 8'(buck_seq_pkg::BLANK_CYC))
            s_nxt.ocHold = sLimit;
          if (s_r.ps && sZero)
          begin
            s_nxt.ph      = buck_seq_pkg::PH_WAIT;
            s_nxt.discontinuous_conduction     = 1'b1;
            s_nxt.ocHold  = 1'b0;
            // Each further light-load cycle in a row adds one fold step, up to seven steps
            s_nxt.foldCnt = 10'(s_r.dcmRun * buck_seq_pkg::FOLD_CYC);
            if (s_r.dcmRun != 3'h7)
              s_nxt.dcmRun = s_r.dcmRun + 3'h1;
          end
          else if (s_r.phCnt >= 8'(buck_seq_pkg::MIN_OFF_CYC - 1)
                   && s_r.phCnt >= 8'(buck_seq_pkg::BLANK_CYC)
                   && sRamp && !s_r.ocHold)
          begin
            s_nxt.ph     = buck_seq_pkg::PH_WAIT;
            s_nxt.dcmRun = 3'h0;
            // Only a ramp-ended low side proves continuous current again
            s_nxt.discontinuous_conduction    = 1'b0;
          end
        end
      endcase
    end

    // Outputs registered from the phase they belong to
    s_nxt.hs = (s_nxt.ph == buck_seq_pkg::PH_ON);
    s_nxt.ls = (s_nxt.ph == buck_seq_pkg::PH_LOW);

    // ----------------------------------------------------------------
    // Output good with blanking
    // ----------------------------------------------------------------
    // Window comparator thresholds sit at -10 % and +20 % of reference
    goodWant = sWindow;
    if (s_r.seq != buck_seq_pkg::SEQ_RUN)
    begin
      s_nxt.good  = 1'b0;
      s_nxt.pgCnt = 12'h000;
    end
    else if (goodWant != s_r.good)
    begin
      if (s_r.pgCnt == 12'(buck_seq_pkg::PG_CYC - 1))
      begin
        s_nxt.good  = goodWant;
        s_nxt.pgCnt = 12'h000;
      end
      else
        s_nxt.pgCnt = s_r.pgCnt + 12'h001;
    end
    else
      s_nxt.pgCnt = 12'h000;
    s_nxt.pullOe = !s_nxt.good;
  end

  // ----------------------------------------------------------------
  // State register; lockout release is the reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r          <= '0;
      s_r.seq      <= buck_seq_pkg::SEQ_STOP;
      s_r.ph       <= buck_seq_pkg::PH_WAIT;
      s_r.pullOe   <= 1'b1;
      s_r.lim      <= buck_seq_pkg::LIM_RST;
      s_r.ps       <= buck_seq_pkg::PS_RST;
      s_r.drv      <= buck_seq_pkg::DRV_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign hsOn          = s_r.hs;
  assign lsOn          = s_r.ls;
  assign ssRefCode     = s_r.ssRef;
  assign limitLevel    = s_r.lim;
  assign powerSaveOn   = s_r.ps;
  assign drvRegOn      = s_r.drv;
  assign outputGood    = s_r.good;
  assign goodPullOe    = s_r.pullOe;
  assign discontinuous = s_r.discontinuous_conduction;
  assign uvFault       = s_r.uvf;
endmodule
`default_nettype wire

// ### hdl/buck_seq_pkg.sv
`default_nettype none
package buck_seq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int ON_TIME_NS   = 500;
  localparam int DEAD_NS      = 20;
  localparam int MIN_OFF_NS   = 250;
  localparam int BLANK_NS     = 100;
  localparam int FOLD_STEP_NS = 1000;
  localparam int UV_FILTER_US = 25;
  localparam int PG_BLANK_US  = 25;
  localparam int ON_CYC       = (ON_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_CYC     = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_OFF_CYC  = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_CYC    = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FOLD_CYC     = (FOLD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_CYC       = (UV_FILTER_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PG_CYC       = (PG_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SS_STEP_DEF  = 125;
  localparam int RETRY_SS_CNT = 20;
  // ----------------------------------------------------------------
  // Soft start, retry, limit and mode codes
  // ----------------------------------------------------------------
  // Reference code in 1 mV steps: 800 mV final
  localparam logic [9:0]  SS_FINAL    = 10'h320;
  localparam int          RETRY_STEPS = RETRY_SS_CNT * int'(SS_FINAL);
  localparam logic [1:0]  LIM_HALF    = 2'h1;
  localparam logic [1:0]  LIM_3Q      = 2'h2;
  localparam logic [1:0]  LIM_FULL    = 2'h3;
  localparam logic [1:0]  LIM_RST     = LIM_FULL;
  localparam logic        PS_RST      = 1'b1;
  localparam logic        DRV_RST     = 1'b1;
  localparam logic [10:0] MODE1_LO    = 11'h000;
  localparam logic [10:0] MODE1_HI    = 11'h064;
  localparam logic [10:0] MODE2_LO    = 11'h12a;
  localparam logic [10:0] MODE2_HI    = 11'h130;
  localparam logic [10:0] MODE3_LO    = 11'h1ee;
  localparam logic [10:0] MODE3_HI    = 11'h1f8;
  localparam logic [10:0] MODE4_LO    = 11'h384;
  localparam logic [10:0] MODE4_HI    = 11'h44c;
  localparam int          SYNC_W      = 22;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_STOP  = 2'h0,
    SEQ_SOFT  = 2'h1,
    SEQ_RUN   = 2'h3,
    SEQ_RETRY = 2'h2
  } seq_e;
  typedef enum logic [1:0] {
    PH_WAIT = 2'h0,
    PH_ON   = 2'h1,
    PH_DEAD = 2'h3,
    PH_LOW  = 2'h2
  } phase_e;
endpackage
`default_nettype wire

// ### hdl/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  // ----------------------------------------------------------------
  // Three stages; a bit moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q  = (~(s_r.s2 ^ s_r.s3) & s_r.s3) | ((s_r.s2 ^ s_r.s3) & s_r.q);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.q;
endmodule
`default_nettype wire

// ### verification/buck_seq_props.sv
`default_nettype none
module buck_seq_props #(
  parameter int SS_STEP_CYC = buck_seq_pkg::SS_STEP_DEF
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        fbOver,
  input wire logic        tempHot,
  input wire logic        fbInWindow,
  input wire logic        limitPinHigh,
  input wire logic        limitPinLow,
  input wire logic [10:0] modeKohm,
  input wire logic        hsOn,
  input wire logic        lsOn,
  input wire logic [9:0]  ssRefCode,
  input wire logic [1:0]  limitLevel,
  input wire logic        powerSaveOn,
  input wire logic        drvRegOn,
  input wire logic        outputGood,
  input wire logic        uvFault
);
  logic [7:0]  hsLen_r;
  logic [7:0]  lsLen_r;
  logic [11:0] winLen_r;

  // ----------------------------------------------------------------
  // Run-length counters
  // ----------------------------------------------------------------
  // Saturating so a long low-side or window stretch never wraps to a short one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hsLen_r  <= 8'h00;
      lsLen_r  <= 8'h00;
      winLen_r <= 12'h000;
    end
    else
    begin
      hsLen_r  <= hsOn ? hsLen_r + 8'h01 : 8'h00;
      lsLen_r  <= lsOn ? lsLen_r + {7'h00, ~&lsLen_r} : 8'h00;
      winLen_r <= fbInWindow ? winLen_r + {11'h000, ~&winLen_r} : 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  hs_width_a: assert property (
    $fell(hsOn) && !tempHot |-> hsLen_r == buck_seq_pkg::ON_CYC) else $error("high pulse length");
  dead_gap_a: assert property (
    $fell(hsOn) && !tempHot |-> !lsOn ##1 !lsOn ##1 lsOn) else $error("dead time wrong");
  no_overlap_a: assert property (
    !(hsOn && lsOn)) else $error("both switches on");
  min_off_a: assert property (
    $fell(lsOn) && !powerSaveOn && !uvFault |-> lsLen_r >= buck_seq_pkg::MIN_OFF_CYC)
    else $error("low side too short");
  over_volt_a: assert property (
    fbOver [*6] |=> !hsOn && !lsOn) else $error("switching during overvoltage");
  uv_off_a: assert property (
    uvFault |-> !hsOn && !lsOn) else $error("switching during undervoltage");
  limit_full_a: assert property (
    (limitPinHigh && !limitPinLow) [*6] |=> limitLevel == buck_seq_pkg::LIM_FULL)
    else $error("full limit decode");
  limit_half_a: assert property (
    (!limitPinHigh && limitPinLow) [*6] |=> limitLevel == buck_seq_pkg::LIM_HALF)
    else $error("half limit decode");
  mode_two_a: assert property (
    (modeKohm == 11'h12d) [*6] |=> !powerSaveOn && drvRegOn) else $error("mode two decode");
  mode_four_a: assert property (
    (modeKohm == 11'h3e8) [*6] |=> powerSaveOn && !drvRegOn) else $error("mode four decode");
  good_delay_a: assert property (
    $rose(outputGood) |-> winLen_r >= buck_seq_pkg::PG_CYC) else $error("good without blanking");
  ss_step_a: assert property (
    !$stable(ssRefCode) |-> ssRefCode == $past(ssRefCode) + 10'h001 || ssRefCode == 10'h000)
    else $error("reference step wrong");

  cover property ($fell(hsOn));
  cover property ($rose(uvFault));
  cover property ($rose(outputGood));
endmodule

bind buck_switch_protection_sequencer buck_seq_props #(.SS_STEP_CYC(SS_STEP_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .fbOver(fbOver), .tempHot(tempHot), .fbInWindow(fbInWindow),
  .limitPinHigh(limitPinHigh), .limitPinLow(limitPinLow), .modeKohm(modeKohm), .hsOn(hsOn),
  .lsOn(lsOn), .ssRefCode(ssRefCode), .limitLevel(limitLevel), .powerSaveOn(powerSaveOn),
  .drvRegOn(drvRegOn), .outputGood(outputGood), .uvFault(uvFault));
`default_nettype wire

// ### verification/gate_drive_model.sv
`default_nettype none
module gate_drive_model (
  input  wire logic       clk,
  input  wire logic       hsOn,
  input  wire logic       lsOn,
  input  wire logic [7:0] zcDelay,
  output logic            zeroCross
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lsTime = 8'h00;

  // Inductor current reaches zero a set time into low-side conduction; 0 means heavy load
  always @(posedge clk)
    lsTime <= (lsOn && !hsOn) ? lsTime + {7'h00, ~&lsTime} : 8'h00;
  assign zeroCross = (zcDelay != 8'h00) && (lsTime >= zcDelay);
endmodule
`default_nettype wire

// ### verification/buck_switch_protection_sequencer_tb_top.sv
`default_nettype none
module buck_switch_protection_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS_STEP = 4;
  localparam int RETRY   = 20 * 800 * SS_STEP;
  logic clk = 1'b0, arst_n = 1'b0, rampCross = 1'b0, overLimit = 1'b0, fbUnder = 1'b0;
  logic fbOver = 1'b0, tempHot = 1'b0, fbAboveRamp = 1'b0, fbInWindow = 1'b0, enable = 1'b0;
  logic limitPinHigh = 1'b1, limitPinLow = 1'b0, zeroCross, hsOn, lsOn, powerSaveOn, drvRegOn;
  logic outputGood, goodPullOe, discontinuous, uvFault;
  logic [10:0] modeKohm = 11'h12d;
  logic [9:0]  ssRefCode;
  logic [1:0]  limitLevel;
  logic [7:0]  zcDelay = 8'h00;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n, k;
  int          gap[3];

  always #5 clk = ~clk;

  buck_switch_protection_sequencer #(.SS_STEP_CYC(SS_STEP)) uut (
    .clk(clk), .arst_n(arst_n), .rampCross(rampCross), .zeroCross(zeroCross),
    .overLimit(overLimit), .fbUnder(fbUnder), .fbOver(fbOver), .tempHot(tempHot),
    .fbAboveRamp(fbAboveRamp), .fbInWindow(fbInWindow), .enable(enable),
    .limitPinHigh(limitPinHigh), .limitPinLow(limitPinLow), .modeKohm(modeKohm), .hsOn(hsOn),
    .lsOn(lsOn), .ssRefCode(ssRefCode), .limitLevel(limitLevel), .powerSaveOn(powerSaveOn),
    .drvRegOn(drvRegOn), .outputGood(outputGood), .goodPullOe(goodPullOe),
    .discontinuous(discontinuous), .uvFault(uvFault));

  gate_drive_model drv (.clk(clk), .hsOn(hsOn), .lsOn(lsOn), .zcDelay(zcDelay),
    .zeroCross(zeroCross));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return hsOn;
      1: return lsOn;
      2: return uvFault;
      3: return ssRefCode == 10'h320;
      default: return outputGood;
    endcase
  endfunction

  // Counts falling edges until the chosen output reaches v, giving up after lim
  task automatic till(input int sel, input logic v, input int lim);
    n = 0;
    while (pick(sel) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic quiet(input int cycles);
    k = 0;
    repeat (cycles)
    begin
      @(negedge clk);
      k += int'(hsOn | lsOn);
    end
  endtask

  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_softstart;
    enable = 1'b1;
    fbAboveRamp = 1'b1;
    rampCross = 1'b1;
    quiet(60);
    chk(16'(k), 16'h0000);
    fbAboveRamp = 1'b0;
    fbOver = 1'b1;
    quiet(60);
    chk(16'(k), 16'h0000);
    fbOver = 1'b0;
    rampCross = 1'b0;
    fbUnder = 1'b1;
    till(3, 1'b1, 4000);
    chk(16'(ssRefCode), 16'h0320);
    chk(16'(uvFault), 16'h0000);
    fbUnder = 1'b0;
  endtask

  task automatic t_cycle;
    rampCross = 1'b1;
    till(0, 1'b1, 20);
    rampCross = 1'b0;
    till(0, 1'b0, 100);
    chk(16'(n), 16'h0032);
    till(1, 1'b1, 10);
    chk(16'(n), 16'h0002);
    rampCross = 1'b1;
    till(1, 1'b0, 100);
    chk(16'(n), 16'h0019);
    till(0, 1'b1, 20);
    chk(16'(hsOn), 16'h0001);
    rampCross = 1'b0;
    till(1, 1'b1, 60);
    overLimit = 1'b1;
    rampCross = 1'b1;
    repeat (100) @(negedge clk);
    chk(16'({hsOn, lsOn}), 16'h0001);
    overLimit = 1'b0;
    till(0, 1'b1, 40);
    chk(16'(hsOn), 16'h0001);
    rampCross = 1'b0;
    till(1, 1'b1, 60);
  endtask

  task automatic t_decode;
    logic [10:0] kohm[9] = '{11'h000, 11'h064, 11'h12a, 11'h130, 11'h1ee, 11'h1f8, 11'h384,
                            11'h44c, 11'h0c8};
    logic [1:0]  expv[9] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2};
    logic [1:0]  pins[3] = '{2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 9; i++)
    begin
      modeKohm = kohm[i];
      repeat (8) @(negedge clk);
      chk(16'({powerSaveOn, drvRegOn}), 16'(expv[i]));
    end
    for (int i = 0; i < 3; i++)
    begin
      {limitPinHigh, limitPinLow} = pins[i];
      repeat (8) @(negedge clk);
      chk(16'(limitLevel), 16'(3 - i));
    end
    {limitPinHigh, limitPinLow} = 2'h2;
  endtask

  task automatic t_powersave;
    modeKohm = 11'h032;
    zcDelay = 8'h28;
    rampCross = 1'b1;
    till(1, 1'b0, 100);
    // Ramp low through the low side so only the zero-cross can end it
    for (int i = 0; i < 3; i++)
    begin
      rampCross = 1'b1;
      till(0, 1'b1, 400);
      gap[i] = n;
      rampCross = 1'b0;
      tempHot = 1'b1;
      till(1, 1'b1, 100);
      till(1, 1'b0, 100);
      chk(16'(n >= 40 && n <= 50), 16'h0001);
    end
    chk(16'(gap[2] - gap[1]), 16'h0064);
    chk(16'(discontinuous), 16'h0001);
    modeKohm = 11'h12d;
    zcDelay = 8'h00;
    rampCross = 1'b1;
    repeat (500) @(negedge clk);
    quiet(100);
    chk(16'(k), 16'h0000);
    tempHot = 1'b0;
    rampCross = 1'b0;
    repeat (20) @(negedge clk);
    chk(16'(ssRefCode < 10'h320), 16'h0001);
    till(3, 1'b1, 4000);
  endtask

  task automatic t_overvolt;
    fbOver = 1'b1;
    repeat (6) @(negedge clk);
    rampCross = 1'b1;
    quiet(100);
    chk(16'(k), 16'h0000);
    fbOver = 1'b0;
    till(0, 1'b1, 20);
    chk(16'(hsOn), 16'h0001);
    rampCross = 1'b0;
    till(1, 1'b1, 60);
  endtask

  task automatic t_good_uv;
    fbInWindow = 1'b1;
    repeat (2400) @(negedge clk);
    chk(16'(outputGood), 16'h0000);
    till(4, 1'b1, 200);
    chk(16'({outputGood, goodPullOe}), 16'h0002);
    fbInWindow = 1'b0;
    fbUnder = 1'b1;
    repeat (2400) @(negedge clk);
    chk(16'({outputGood, uvFault}), 16'h0002);
    till(2, 1'b1, 200);
    chk(16'({uvFault, hsOn, lsOn, goodPullOe}), 16'h0009);
    till(2, 1'b0, RETRY + 100);
    chk(16'(n > RETRY - 20 && n < RETRY + 20), 16'h0001);
    repeat (10) @(negedge clk);
    chk(16'(ssRefCode < 10'h320), 16'h0001);
    fbUnder = 1'b0;
    till(3, 1'b1, 4000);
    enable = 1'b0;
    repeat (8) @(negedge clk);
    chk(16'({hsOn, lsOn, outputGood}), 16'h0000);
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    chk(16'({limitLevel, powerSaveOn, drvRegOn, outputGood, goodPullOe}), 16'h003d);
    chk(16'({ssRefCode, uvFault, hsOn, lsOn}), 16'h0000);
    arst_n = 1'b1;
    t_softstart;
    t_cycle;
    t_decode;
    t_powersave;
    t_overvolt;
    t_good_uv;
    give_verdict;
  end

  initial
  begin
    repeat (97000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule
`default_nettype wire
